// File: rtl/tco_pkg.sv
// package: register map, field layouts and modes of the timer channel output block
package tco_pkg;
  localparam int ADDR_W = 8;
  localparam int IDX_CTRL = 6;
  localparam int IDX_SCR = 7;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = ADDR_W'(IDX_CTRL * 4);
  localparam logic [ADDR_W-1:0] ADDR_SCR = ADDR_W'(IDX_SCR * 4);

  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] SCR_RESET = 16'h0000;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam logic [2:0] OM_ACTIVE = 3'h0;
  localparam logic [2:0] OM_CLEAR = 3'h1;
  localparam logic [2:0] OM_SET = 3'h2;
  localparam logic [2:0] OM_TOGGLE = 3'h3;
  localparam logic [2:0] OM_ALT = 3'h4;
  localparam logic [2:0] OM_SET_SEC = 3'h5;
  localparam logic [2:0] OM_SET_ROLL = 3'h6;
  localparam logic [2:0] OM_GATED = 3'h7;

  localparam logic [1:0] CM_OFF = 2'h0;
  localparam logic [1:0] CM_RISE = 2'h1;
  localparam logic [1:0] CM_FALL = 2'h2;
  localparam logic [1:0] CM_BOTH = 2'h3;

  // channel control word, bit 15 first
  typedef struct packed {
    logic [2:0] count_mode;
    logic [3:0] primary_src;
    logic [1:0] secondary_src;
    logic count_single;
    logic count_length;
    logic count_down;
    logic cochannel_reinit_enable;
    logic [2:0] out_mode;
  } tco_ctrl_t;

  // status and control word, bit 15 first
  typedef struct packed {
    logic compare_flag;
    logic compare_irq_enable;
    logic overflow_flag;
    logic overflow_irq_enable;
    logic edge_flag;
    logic edge_irq_enable;
    logic input_polarity;
    logic input_level;
    logic [1:0] capture_mode;
    logic broadcast_master;
    logic external_force_enable;
    logic forced_level;
    logic force_cmd;
    logic output_polarity;
    logic pin_drive_enable;
  } tco_scr_t;

  typedef enum logic [2:0] {
    WS_COLLECT = 3'b001,
    WS_EXEC = 3'b010,
    WS_RESP = 3'b100
  } tco_wstate_t;
endpackage

// File: rtl/tco_channel.sv
// module: output flag, status flags, capture control and force logic of one timer channel
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module tco_channel
  import tco_pkg::*;
(
  input wire logic REF_CLK, // 250 MHz clock
  input wire logic RSTN, // sync reset, active low
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR, // write address
  input wire logic S_AXI_AWVALID, // write address valid
  output logic S_AXI_AWREADY, // write address ready
  input wire logic [31:0] S_AXI_WDATA, // write data
  input wire logic [3:0] S_AXI_WSTRB, // write byte strobes
  input wire logic S_AXI_WVALID, // write data valid
  output logic S_AXI_WREADY, // write data ready
  output logic [1:0] S_AXI_BRESP, // write response
  output logic S_AXI_BVALID, // write response valid
  input wire logic S_AXI_BREADY, // write response ready
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR, // read address
  input wire logic S_AXI_ARVALID, // read address valid
  output logic S_AXI_ARREADY, // read address ready
  output logic [31:0] S_AXI_RDATA, // read data
  output logic [1:0] S_AXI_RRESP, // read response
  output logic S_AXI_RVALID, // read data valid
  input wire logic S_AXI_RREADY, // read data ready
  input wire logic COMPARE_HIT, // successful compare pulse from core
  input wire logic ROLLOVER, // counter rolled past limit pulse
  input wire logic CNT_ACTIVE, // counter active level
  input wire logic GATE_SRC, // primary source clock level
  input wire logic SEC_EDGE, // secondary source edge pulse
  input wire logic CO_CMP_IN, // compare broadcast from a master
  input wire logic PIN_IN, // external pin level
  input wire logic PIN_FROM_TIMER, // pin driven by another timer group
  output logic PIN_OUT, // pin drive value
  output logic PIN_OE_N, // pin output enable, low drives
  output logic CMP_BCAST_OUT, // compare broadcast to co-channels
  output logic REINIT_OUT, // reinit request to core
  output logic CMP_SEL_DOWN, // core compares against down value
  output logic CAPTURE_LOAD, // load capture register pulse
  output logic IRQ_COMPARE, // compare interrupt request
  output logic IRQ_OVERFLOW, // overflow interrupt request
  output logic IRQ_EDGE, // input edge interrupt request
  output tco_ctrl_t CTRL_OUT // control word to counter core
);

  tco_wstate_t wstate;
  logic [ADDR_W-1:0] wr_addr;
  logic [15:0] wr_data;
  logic [1:0] wr_strb;
  tco_ctrl_t ctrl;
  tco_scr_t status_control;
  logic timer_out_flag;
  logic pin_prev;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] data,
                                          input logic [1:0] strb);
    merge16 = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
  endfunction

  function automatic logic zero_write(input logic en, input logic strb, input logic bit_val);
    zero_write = en & strb & ~bit_val;
  endfunction

  // write path decode
  wire aw_hs = S_AXI_AWVALID & S_AXI_AWREADY;
  wire w_hs = S_AXI_WVALID & S_AXI_WREADY;
  wire aw_have = aw_hs | ~S_AXI_AWREADY;
  wire w_have = w_hs | ~S_AXI_WREADY;
  wire exec = (wstate == WS_EXEC);
  wire wr_ctrl = exec & (wr_addr == ADDR_CTRL);
  wire wr_scr = exec & (wr_addr == ADDR_SCR);
  wire wr_bad = exec & ~wr_ctrl & ~wr_scr;
  wire [15:0] scr_merged = merge16(status_control, wr_data, wr_strb);
  wire tco_scr_t scr_w = scr_merged;
  wire [15:0] ctrl_merged = merge16(ctrl, wr_data, wr_strb);

  // read path decode
  wire ar_hs = S_AXI_ARVALID & S_AXI_ARREADY;
  wire rd_ctrl = (S_AXI_ARADDR == ADDR_CTRL);
  wire rd_scr = (S_AXI_ARADDR == ADDR_SCR);
  wire [15:0] rd_word = rd_ctrl ? ctrl : (rd_scr ? status_control : 16'h0000);

  // input conditioning and capture
  wire pin_level = PIN_IN ^ (status_control.input_polarity & ~PIN_FROM_TIMER);
  wire pin_rise = pin_level & ~pin_prev;
  wire pin_fall = ~pin_level & pin_prev;
  wire edge_sel = (status_control.capture_mode == CM_RISE) ? pin_rise :
                  (status_control.capture_mode == CM_FALL) ? pin_fall :
                  (status_control.capture_mode == CM_BOTH) ? (pin_rise | pin_fall) : 1'b0;
  wire cap_hit = edge_sel & ~status_control.edge_flag;

  // flag clears by zero write on the high byte
  wire clr_cmp = zero_write(wr_scr, wr_strb[1], wr_data[15]);
  wire clr_ovf = zero_write(wr_scr, wr_strb[1], wr_data[13]);
  wire clr_edge = zero_write(wr_scr, wr_strb[1], wr_data[11]);
  wire next_cmp_flag = COMPARE_HIT | (status_control.compare_flag & ~clr_cmp);
  wire next_ovf_flag = ROLLOVER | (status_control.overflow_flag & ~clr_ovf);
  wire next_edge_flag = cap_hit | (status_control.edge_flag & ~clr_edge);

  // control bits after this cycle's write
  wire tco_scr_t scr_ctl = wr_scr ? scr_w : status_control;
  wire [2:0] omode = ctrl.out_mode;

  // force sources share the forced level
  wire sw_force = wr_scr & wr_strb[0] & wr_data[2];
  wire ext_force = status_control.external_force_enable & CO_CMP_IN;
  wire force_any = sw_force | ext_force;

  // output flag behaviour by mode
  wire mode_flag =
    (omode == OM_ACTIVE) ? CNT_ACTIVE :
    (omode == OM_GATED) ? (CNT_ACTIVE & GATE_SRC) :
    (omode == OM_CLEAR) ? (COMPARE_HIT ? 1'b0 : timer_out_flag) :
    (omode == OM_SET) ? (COMPARE_HIT ? 1'b1 : timer_out_flag) :
    (omode == OM_TOGGLE || omode == OM_ALT) ? (timer_out_flag ^ COMPARE_HIT) :
    (omode == OM_SET_SEC) ? (COMPARE_HIT | (timer_out_flag & ~SEC_EDGE)) :
    (COMPARE_HIT | (timer_out_flag & ~ROLLOVER));
  wire next_timer_out_flag = force_any ? scr_ctl.forced_level : mode_flag;

  wire next_reinit = (ctrl.cochannel_reinit_enable & CO_CMP_IN) |
                     ((omode == OM_ALT) & COMPARE_HIT);

  always_ff @(posedge REF_CLK)
  begin
    if (!RSTN)
    begin
      wstate <= WS_COLLECT;
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY <= 1'b1;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= RESP_OKAY;
      wr_addr <= '0;
      wr_data <= 16'h0000;
      wr_strb <= 2'h0;
    end
    else
    begin
      if (aw_hs)
      begin
        wr_addr <= S_AXI_AWADDR;
        S_AXI_AWREADY <= 1'b0;
      end
      if (w_hs)
      begin
        wr_data <= S_AXI_WDATA[15:0];
        wr_strb <= S_AXI_WSTRB[1:0];
        S_AXI_WREADY <= 1'b0;
      end
      case (wstate)
        WS_COLLECT:
        begin
          if (aw_have && w_have)
            wstate <= WS_EXEC;
        end
        WS_EXEC:
        begin
          S_AXI_BVALID <= 1'b1;
          S_AXI_BRESP <= wr_bad ? RESP_SLVERR : RESP_OKAY;
          wstate <= WS_RESP;
        end
        WS_RESP:
        begin
          if (S_AXI_BREADY)
          begin
            S_AXI_BVALID <= 1'b0;
            S_AXI_AWREADY <= 1'b1;
            S_AXI_WREADY <= 1'b1;
            wstate <= WS_COLLECT;
          end
        end
        default:
          wstate <= WS_COLLECT;
      endcase
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RSTN)
    begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h00000000;
      S_AXI_RRESP <= RESP_OKAY;
    end
    else if (ar_hs)
    begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= {16'h0000, rd_word};
      S_AXI_RRESP <= (rd_ctrl | rd_scr) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (S_AXI_RVALID && S_AXI_RREADY)
    begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
    end
  end

  // registers and flags
  always_ff @(posedge REF_CLK)
  begin
    if (!RSTN)
    begin
      ctrl <= CTRL_RESET;
      status_control <= SCR_RESET;
      pin_prev <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl <= ctrl_merged;
      status_control <= scr_ctl;
      status_control.force_cmd <= 1'b0;
      status_control.input_level <= pin_level;
      status_control.compare_flag <= next_cmp_flag;
      status_control.overflow_flag <= next_ovf_flag;
      status_control.edge_flag <= next_edge_flag;
      pin_prev <= pin_level;
    end
  end

  // output flag, pin and channel outputs
  always_ff @(posedge REF_CLK)
  begin
    if (!RSTN)
    begin
      timer_out_flag <= 1'b0;
      PIN_OUT <= 1'b0;
      PIN_OE_N <= 1'b1;
      CMP_BCAST_OUT <= 1'b0;
      REINIT_OUT <= 1'b0;
      CMP_SEL_DOWN <= 1'b0;
      CAPTURE_LOAD <= 1'b0;
      IRQ_COMPARE <= 1'b0;
      IRQ_OVERFLOW <= 1'b0;
      IRQ_EDGE <= 1'b0;
      CTRL_OUT <= CTRL_RESET;
    end
    else
    begin
      timer_out_flag <= next_timer_out_flag;
      PIN_OUT <= next_timer_out_flag ^ scr_ctl.output_polarity;
      PIN_OE_N <= ~scr_ctl.pin_drive_enable;
      CMP_BCAST_OUT <= status_control.broadcast_master & COMPARE_HIT;
      REINIT_OUT <= next_reinit;
      if (omode != OM_ALT)
        CMP_SEL_DOWN <= 1'b0;
      else if (COMPARE_HIT)
        CMP_SEL_DOWN <= ~CMP_SEL_DOWN;
      CAPTURE_LOAD <= cap_hit;
      IRQ_COMPARE <= status_control.compare_flag & status_control.compare_irq_enable;
      IRQ_OVERFLOW <= status_control.overflow_flag & status_control.overflow_irq_enable;
      IRQ_EDGE <= status_control.edge_flag & status_control.edge_irq_enable & (status_control.capture_mode != CM_OFF);
      CTRL_OUT <= wr_ctrl ? tco_ctrl_t'(ctrl_merged) : ctrl;
    end
  end

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RSTN);

  cmp_flag_set_a: assert property (COMPARE_HIT |=> status_control.compare_flag)
    else $error("compare flag not set after compare");
  cmp_flag_keep_a: assert property (status_control.compare_flag && !clr_cmp |=> status_control.compare_flag)
    else $error("compare flag lost without zero write");
  ovf_irq_gate_a: assert property (IRQ_OVERFLOW |-> $past(status_control.overflow_flag)
                                   && $past(status_control.overflow_irq_enable))
    else $error("overflow interrupt without flag and enable");
  cmp_irq_path_a: assert property (status_control.compare_flag && status_control.compare_irq_enable
                                   |=> IRQ_COMPARE)
    else $error("compare interrupt missing");
  edge_irq_mode_a: assert property (status_control.capture_mode == CM_OFF |=> !IRQ_EDGE)
    else $error("edge interrupt with capture off");
  cap_lock_a: assert property ($past(status_control.edge_flag) |-> !CAPTURE_LOAD)
    else $error("capture while edge flag set");
  toggle_mode_a: assert property (omode == OM_TOGGLE && COMPARE_HIT && !force_any
                                  |=> timer_out_flag != $past(timer_out_flag))
    else $error("flag did not toggle on compare");
  ext_force_a: assert property (ext_force && !wr_scr |=> timer_out_flag == $past(status_control.forced_level))
    else $error("external force did not apply level");
  pin_polarity_a: assert property (PIN_OUT == (timer_out_flag ^ status_control.output_polarity))
    else $error("pin value mismatch with flag and polarity");
  reinit_co_a: assert property (ctrl.cochannel_reinit_enable && CO_CMP_IN
                                |=> REINIT_OUT)
    else $error("co-channel reinit not requested");
  bcast_a: assert property (!status_control.broadcast_master |=> !CMP_BCAST_OUT)
    else $error("broadcast without master bit");

  // output flag and alternate compare target per mode
  set_mode_a: assert property (omode == OM_SET && COMPARE_HIT && !force_any
                               |=> timer_out_flag)
    else $error("flag not set on compare");
  clear_mode_a: assert property (omode == OM_CLEAR && COMPARE_HIT && !force_any
                                 |=> !timer_out_flag)
    else $error("flag not cleared on compare");
  active_mode_a: assert property (omode == OM_ACTIVE && !force_any
                                  |=> timer_out_flag == $past(CNT_ACTIVE))
    else $error("flag does not follow counter activity");
  gated_mode_a: assert property (omode == OM_GATED && !force_any
                                 |=> timer_out_flag == ($past(CNT_ACTIVE) && $past(GATE_SRC)))
    else $error("gated clock output wrong");
  alt_select_a: assert property (omode == OM_ALT && COMPARE_HIT
                                 |=> CMP_SEL_DOWN != $past(CMP_SEL_DOWN) && REINIT_OUT)
    else $error("alternate compare target not switched");
  sec_clear_a: assert property (omode == OM_SET_SEC && SEC_EDGE
                                && !COMPARE_HIT && !force_any |=> !timer_out_flag)
    else $error("flag not cleared on secondary edge");
  roll_clear_a: assert property (omode == OM_SET_ROLL && ROLLOVER
                                 && !COMPARE_HIT && !force_any |=> !timer_out_flag)
    else $error("flag not cleared on rollover");
  roll_set_a: assert property (omode == OM_SET_ROLL && COMPARE_HIT && !force_any
                               |=> timer_out_flag)
    else $error("compare did not win over rollover");
  // status flags and capture
  ovf_flag_set_a: assert property (ROLLOVER |=> status_control.overflow_flag)
    else $error("overflow flag not set after rollover");
  ovf_flag_keep_a: assert property (status_control.overflow_flag && !clr_ovf
                                    |=> status_control.overflow_flag)
    else $error("overflow flag lost without zero write");
  edge_flag_set_a: assert property (CAPTURE_LOAD |-> status_control.edge_flag)
    else $error("edge flag not set on capture");
  cap_off_a: assert property (status_control.capture_mode == CM_OFF |=> !CAPTURE_LOAD)
    else $error("capture with capture mode off");
  input_level_a: assert property (!PIN_FROM_TIMER
                                  |=> status_control.input_level == ($past(PIN_IN) ^ $past(status_control.input_polarity)))
    else $error("input level bit wrong for external pin");
  timer_level_a: assert property (PIN_FROM_TIMER
                                  |=> status_control.input_level == $past(PIN_IN))
    else $error("input from timer group inverted");
  // force, read-back, broadcast and pin
  sw_force_a: assert property (sw_force |=> timer_out_flag == $past(wr_data[3]))
    else $error("software force did not apply level");
  force_read_a: assert property (ar_hs && rd_scr |=> !S_AXI_RDATA[2])
    else $error("force bit read as one");
  pin_enable_a: assert property (PIN_OE_N == !status_control.pin_drive_enable)
    else $error("pin enable mismatch with drive bit");
  bcast_hit_a: assert property (status_control.broadcast_master && COMPARE_HIT
                                |=> CMP_BCAST_OUT)
    else $error("master compare not broadcast");
  reinit_off_a: assert property (!ctrl.cochannel_reinit_enable && omode != OM_ALT
                                 |=> !REINIT_OUT)
    else $error("reinit without enable");

  cov_capture_c: cover property (CAPTURE_LOAD ##1 IRQ_EDGE);
  cov_alt_c: cover property (omode == OM_ALT && COMPARE_HIT ##1 CMP_SEL_DOWN);
  cov_set_clear_c: cover property (COMPARE_HIT && clr_cmp);
  cov_write_c: cover property (S_AXI_BVALID && S_AXI_BREADY);
  cov_force_c: cover property (ext_force ##1 timer_out_flag);

endmodule

// File: tb/tco_peer.sv
// model of the shared timer pin and of a sibling master channel
`timescale 1ns/1ns
module tco_peer
  import tco_pkg::*;
(
  input wire logic REF_CLK, // channel clock
  input wire logic PIN_OUT, // value the channel drives
  input wire logic PIN_OE_N, // low while the channel drives
  output logic PIN_IN, // resolved pin level
  output logic CO_CMP_IN // compare broadcast of the sibling
);
  logic ext_level;

  initial
  begin
    ext_level = 1'h0;
    CO_CMP_IN = 1'h0;
  end

  // pin shows the channel drive, else the outside source
  assign PIN_IN = PIN_OE_N ? ext_level : PIN_OUT;

  task automatic set_ext(input logic v);
    @(posedge REF_CLK);
    ext_level <= v;
  endtask

  // one-cycle compare broadcast of a master sibling
  task automatic fire();
    @(posedge REF_CLK);
    CO_CMP_IN <= 1'h1;
    @(posedge REF_CLK);
    CO_CMP_IN <= 1'h0;
  endtask
endmodule

// File: tb/test_timer_channel_output_status.sv
// self-checking bench for the timer channel output block
`timescale 1ns/1ns
module test_timer_channel_output_status
  import tco_pkg::*;
  ;
  typedef struct packed {logic [2:0] mode; logic start; logic [1:0] ev; logic exp;} tco_row_t;
  logic clk, rstn, awvalid, wvalid, bready, arvalid, rready;
  logic cmp_hit, roll, act, gate, sec, pin_from;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata;
  logic [3:0] wstrb, strb_sel;
  wire awready, wready, bvalid, arready, rvalid, pin_out, oe_n, bcast, reinit, sel_down;
  wire cap_load, irq_c, irq_o, irq_e, pin_in, co_cmp;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  tco_ctrl_t ctrl_out;
  logic [1:0] resp;
  logic [15:0] rd;
  int n_mismatch, checked, cyc, n_cap, n_re, n_bc, base;
  // ev: 0 compare, 1 secondary edge, 2 rollover, 3 active with gate high
  tco_row_t rows [12] = '{'{OM_CLEAR, 1, 0, 0}, '{OM_SET, 0, 0, 1}, '{OM_TOGGLE, 0, 0, 1},
    '{OM_TOGGLE, 1, 0, 0}, '{OM_ALT, 0, 0, 1}, '{OM_ALT, 1, 0, 0}, '{OM_SET_SEC, 1, 1, 0},
    '{OM_SET_SEC, 0, 0, 1}, '{OM_SET_ROLL, 1, 2, 0}, '{OM_SET_ROLL, 0, 0, 1},
    '{OM_ACTIVE, 0, 3, 1}, '{OM_GATED, 0, 3, 1}};

  tco_channel i_dut (
    .REF_CLK(clk), .RSTN(rstn), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .COMPARE_HIT(cmp_hit), .ROLLOVER(roll), .CNT_ACTIVE(act), .GATE_SRC(gate),
    .SEC_EDGE(sec), .CO_CMP_IN(co_cmp), .PIN_IN(pin_in), .PIN_FROM_TIMER(pin_from),
    .PIN_OUT(pin_out), .PIN_OE_N(oe_n), .CMP_BCAST_OUT(bcast), .REINIT_OUT(reinit),
    .CMP_SEL_DOWN(sel_down), .CAPTURE_LOAD(cap_load), .IRQ_COMPARE(irq_c),
    .IRQ_OVERFLOW(irq_o), .IRQ_EDGE(irq_e), .CTRL_OUT(ctrl_out));
  tco_peer i_peer (.REF_CLK(clk), .PIN_OUT(pin_out), .PIN_OE_N(oe_n), .PIN_IN(pin_in),
    .CO_CMP_IN(co_cmp));

  initial
  begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  task automatic end_of_test();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      $display("mismatch %s expected %h seen %h", n, e, g);
      n_mismatch++;
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= {16'h0000, d};
    wstrb <= strb_sel;
    {awvalid, wvalid, bready} <= 3'h7;
    do
    begin
      @(posedge clk);
      if (awvalid && awready === 1'h1) awvalid <= 1'h0;
      if (wvalid && wready === 1'h1) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    resp = bresp;
    bready <= 1'h0;
  endtask

  task automatic rdr(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do
    begin
      @(posedge clk);
      if (arvalid && arready === 1'h1) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    resp = rresp;
    rd = rdata[15:0];
    rready <= 1'h0;
  endtask

  task automatic pulse(input logic [1:0] ev);
    @(posedge clk);
    {cmp_hit, sec, roll} <= {ev == 2'h0, ev == 2'h1, ev == 2'h2};
    @(posedge clk);
    {cmp_hit, sec, roll} <= 3'h0;
  endtask

  // pulse counters and hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cap_load === 1'h1) n_cap <= n_cap + 1;
    if (reinit === 1'h1) n_re <= n_re + 1;
    if (bcast === 1'h1) n_bc <= n_bc + 1;
    if (cyc == 5000)
    begin
      n_mismatch++;
      end_of_test();
    end
  end

  initial
  begin
    {rstn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {cmp_hit, roll, act, gate, sec, pin_from} = 6'h00;
    {awaddr, araddr, wdata, wstrb} = '0;
    strb_sel = 4'h3;
    repeat (10) @(posedge clk);
    rstn <= 1'h1;
    chk("oe_n", 1, oe_n);
    chk("irq", 0, {irq_c, irq_o, irq_e});
    rdr(ADDR_CTRL);
    chk("ctrl rst", {RESP_OKAY, CTRL_RESET}, {resp, rd});
    rdr(ADDR_SCR);
    chk("scr rst", {RESP_OKAY, SCR_RESET}, {resp, rd});
    rdr(8'h00);
    chk("unmapped rd", {RESP_SLVERR, 16'h0000}, {resp, rd});
    wr(8'h00, 16'hFFFF);
    chk("unmapped wr", RESP_SLVERR, resp);
    wr(ADDR_CTRL, 16'h1234);
    rdr(ADDR_CTRL);
    chk("ctrl rw", {16'h1234, 16'h1234}, {rd, ctrl_out});
    $display("test registers done");
    foreach (rows[i])
    begin
      wr(ADDR_CTRL, {13'h0000, rows[i].mode});
      wr(ADDR_SCR, {12'h000, rows[i].start, 3'h5});
      if (rows[i].ev == 2'h3)
        {act, gate} <= 2'h3;
      else
        pulse(rows[i].ev);
      tick(3);
      chk("flag", rows[i].exp, pin_out);
      if (rows[i].mode == OM_ALT) chk("sel_down", !rows[i].start, sel_down);
      {act, gate} <= 2'h0;
    end
    tick(1);
    act <= 1'h1;
    tick(3);
    chk("gate low", 0, pin_out);
    gate <= 1'h1;
    tick(2);
    chk("gate high", 1, pin_out);
    {act, gate} <= 2'h0;
    $display("test output modes done");
    wr(ADDR_CTRL, 16'h0002);
    wr(ADDR_SCR, 16'h5000);
    pulse(2'h0);
    pulse(2'h2);
    tick(3);
    chk("irq on", 2'h3, {irq_c, irq_o});
    rdr(ADDR_SCR);
    chk("flags set", 16'hF000, rd);
    wr(ADDR_SCR, 16'hA000);
    tick(2);
    rdr(ADDR_SCR);
    chk("flags kept", {16'hA000, 2'h0}, {rd, irq_c, irq_o});
    strb_sel = 4'h1;
    wr(ADDR_SCR, 16'h0000);
    strb_sel = 4'h3;
    rdr(ADDR_SCR);
    chk("low strobe", 16'hA000, rd);
    wr(ADDR_SCR, 16'h5000);
    tick(2);
    rdr(ADDR_SCR);
    chk("flags clr", {16'h5000, 2'h0}, {rd, irq_c, irq_o});
    $display("test flags done");
    wr(ADDR_SCR, 16'h0440);
    i_peer.set_ext(1'h1);
    tick(3);
    rdr(ADDR_SCR);
    chk("edge", {16'h0D40, 1'h1}, {rd, irq_e});
    i_peer.set_ext(1'h0);
    i_peer.set_ext(1'h1);
    tick(3);
    chk("cap locked", 1, n_cap);
    wr(ADDR_SCR, 16'h0400);
    i_peer.set_ext(1'h0);
    i_peer.set_ext(1'h1);
    tick(3);
    chk("cap off", {31'h1, 1'h0}, {n_cap[30:0], irq_e});
    wr(ADDR_SCR, 16'h0240);
    i_peer.set_ext(1'h0);
    tick(3);
    rdr(ADDR_SCR);
    chk("ips", {16'h0B40, 2'h2}, {rd, n_cap[1:0]});
    pin_from <= 1'h1;
    tick(2);
    rdr(ADDR_SCR);
    chk("from timer", 16'h0A40, rd);
    pin_from <= 1'h0;
    wr(ADDR_SCR, 16'h0000);
    $display("test capture done");
    wr(ADDR_CTRL, 16'h000A);
    base = n_re;
    i_peer.fire();
    tick(3);
    wr(ADDR_CTRL, 16'h0002);
    i_peer.fire();
    tick(3);
    chk("reinit", base + 1, n_re);
    wr(ADDR_SCR, 16'h0005);
    rdr(ADDR_SCR);
    chk("force rd", 16'h0001, rd);
    wr(ADDR_SCR, 16'h0019);
    i_peer.fire();
    tick(3);
    chk("ext force", 1, pin_out);
    wr(ADDR_SCR, 16'h0005);
    wr(ADDR_SCR, 16'h0009);
    i_peer.fire();
    tick(3);
    chk("no force", 0, pin_out);
    wr(ADDR_SCR, 16'h0003);
    tick(2);
    chk("ops", 2'h2, {pin_out, oe_n});
    wr(ADDR_SCR, 16'h0020);
    pulse(2'h0);
    tick(3);
    wr(ADDR_SCR, 16'h0000);
    pulse(2'h0);
    tick(3);
    chk("bcast", 1, n_bc);
    $display("test force and broadcast done");
    wr(ADDR_SCR, 16'h5003);
    rstn <= 1'h0;
    tick(2);
    rstn <= 1'h1;
    chk("reset pin", 2'h1, {pin_out, oe_n});
    rdr(ADDR_SCR);
    chk("reset scr", {RESP_OKAY, SCR_RESET}, {resp, rd});
    $display("test reset done");
    end_of_test();
  end
endmodule
